// File: design/sfp_pkg.sv
// Shared constants and types of the serial flash programming link.
// Assumes both ends run on a 125 MHz clock.
package sfp_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   // Cycles of 8 ns, rounded up
   localparam logic [11:0] PULSE_CYC = 12'h07d;
   localparam logic [11:0] SELECT_CYC = 12'h0bc;
   localparam logic [11:0] SETTLE_CYC = 12'h0fa;
   localparam logic [11:0] EXIT_CYC = 12'h0fa;
   localparam logic [11:0] END_CYC = 12'h177;
   localparam logic [11:0] SCK_HALF_CYC = 12'h010;

   // ----------------------------------------------------------------
   // Link selection
   // ----------------------------------------------------------------
   localparam logic [4:0] PULSES_HW = 5'h00;
   localparam logic [4:0] PULSES_PSEUDO = 5'h0c;
   localparam logic [4:0] PULSES_MAX = 5'h1f;
   localparam logic [1:0] MODE_NONE = 2'h0;
   localparam logic [1:0] MODE_HW = 2'h1;
   localparam logic [1:0] MODE_PSEUDO = 2'h2;

   // ----------------------------------------------------------------
   // Commands, array and status layout
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_ERASE = 8'h01;
   localparam logic [7:0] CMD_BLANK = 8'h02;
   localparam logic [7:0] CMD_WRITE = 8'h03;
   localparam logic [7:0] CMD_VERIFY = 8'h04;
   localparam logic [7:0] CMD_STATUS = 8'h05;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam int FLASH_BYTES_DEF = 16384;
   localparam int FIFO_DEPTH_DEF = 8;
   localparam int ST_BUSY = 0;
   localparam int ST_BLANK_OK = 1;
   localparam int ST_VERIFY_FAIL = 2;
   localparam int ST_BAD_CMD = 3;
   localparam int ST_BLOCKED = 4;
   localparam int ST_OVERRUN = 5;
   localparam int ST_MODE_LSB = 6;
   // Synchroniser bit positions on the device side
   localparam int SY_VPP = 0;
   localparam int SY_HCK = 1;
   localparam int SY_HDI = 2;
   localparam int SY_PCK = 3;
   localparam int SY_PDI = 4;

   // ----------------------------------------------------------------
   // State encodings
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      L_OFF = 4'h1, L_INIT = 4'h2, L_LINK = 4'h4, L_BAD = 4'h8
   } sfp_link_e;
   typedef enum logic [7:0] {
      E_IDLE = 8'h01, E_ERASE = 8'h02, E_BLANK = 8'h04, E_ADRH = 8'h08,
      E_ADRL = 8'h10, E_CNT = 8'h20, E_DATA = 8'h40, E_VERIFY = 8'h80
   } sfp_eng_e;
   typedef enum logic [7:0] {
      P_IDLE = 8'h01, P_HI = 8'h02, P_LO = 8'h04, P_SETTLE = 8'h08,
      P_READY = 8'h10, P_CKLO = 8'h20, P_CKHI = 8'h40, P_END = 8'h80
   } sfp_prg_e;

endpackage : sfp_pkg

// File: design/sfp_link_if.sv
// Pins between the target device and the external programmer.
// Enables are high while the owner drives; the bench resolves the wire.
`timescale 1ns/100ps
interface sfp_link_if;
   logic vpp;
   logic crystal_input;
   logic crystal_input_oe;
   logic sio_clock_pin;
   logic sio_data_in_pin;
   logic sio_data_out_pin;
   logic sio_data_out_pin_oe;
   logic port_one_bit_zero;
   logic port_one_bit_two;
   logic port_one_bit_one;
   logic port_one_bit_one_oe;

   modport dev (
      input vpp, crystal_input, sio_clock_pin, sio_data_in_pin,
      input port_one_bit_zero, port_one_bit_two,
      output sio_data_out_pin, sio_data_out_pin_oe, port_one_bit_one, port_one_bit_one_oe
   );
   modport prg (
      output vpp, crystal_input, crystal_input_oe, sio_clock_pin, sio_data_in_pin,
      output port_one_bit_zero, port_one_bit_two,
      input sio_data_out_pin, port_one_bit_one
   );
endinterface : sfp_link_if

// File: design/sfp_device.sv
// Target end: link selection by pulse count, serial byte link, command
// engine over the flash array, and the receive FIFO between them.
// Assumes link pins are asynchronous to i_clock and sck is slow
// (half period of several device cycles).
//
// Operation
// (RL1) No pulses select the hardware serial port
// (RL2) Twelve pulses select the port one link
// (RL3) Port one link moves bits through port pins
// (RL4) Unused pins stay in their reset state
// (RL5) Programmer pulses before commands, defined counts only
// (RL6) All operations travel as commands over link
// (RL7) Batch erase clears the whole array
// (RL8) Blank check reports whether everything is erased
// (RL9) Write takes address, count, then consecutive bytes
// (RL10) Verify compares whole array, flags any mismatch
// (RL11) Programmer clocks the target only without resonator
// (RL12) Any other count enables no link
// (RL13) Programming pin sets mode and enables writes
`timescale 1ns/100ps

// ------------------------------------------------------------------
// Receive FIFO
// ------------------------------------------------------------------
module sfp_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_nrst,
   // Fill side
   input wire logic i_valid,
   input wire logic [W-1:0] i_data,
   output logic o_ready,
   // Drain side
   output logic o_valid,
   output logic [W-1:0] o_data,
   input wire logic i_ready
);
   localparam int AW = $clog2(DEPTH);
   // Pointers wrap naturally, so DEPTH must be a power of two
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } sfp_fifo_s;
   sfp_fifo_s st_r;
   sfp_fifo_s st_nxt;
   logic [W-1:0] mem [DEPTH];
   logic push;
   logic pop;

   assign o_ready = (st_r.cnt != (AW+1)'(DEPTH));
   assign o_valid = (st_r.cnt != '0);
   assign o_data = mem[st_r.rp];
   assign push = i_valid & o_ready;
   assign pop = o_valid & i_ready;

   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.wp = st_r.wp + 1'b1;
      end
      if (pop) begin
         st_nxt.rp = st_r.rp + 1'b1;
      end
      if (push && !pop) begin
         st_nxt.cnt = st_r.cnt + 1'b1;
      end else if (pop && !push) begin
         st_nxt.cnt = st_r.cnt - 1'b1;
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   always_ff @(posedge i_clock) begin
      if (push) begin
         mem[st_r.wp] <= i_data;
      end
   end
endmodule : sfp_fifo

// ------------------------------------------------------------------
// Device end
// ------------------------------------------------------------------
module sfp_device import sfp_pkg::*; #(
   parameter int FLASH_BYTES = FLASH_BYTES_DEF,
   parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_nrst,
   // Link pins
   sfp_link_if.dev link,
   // User side
   output logic [1:0] o_link_mode,
   output logic o_busy,
   output logic [7:0] o_status
);
   localparam int AW = $clog2(FLASH_BYTES);

   typedef struct packed {
      logic [4:0] s1;
      logic [4:0] s2;
      logic [4:0] s3;
      sfp_link_e lst;
      logic pseudo;
      logic [4:0] pulses;
      logic [11:0] tcnt;
      logic [2:0] bitcnt;
      logic [7:0] rx;
      logic [7:0] tx;
      logic doe_hw;
      logic doe_p1;
      logic push;
      logic [7:0] pushd;
      sfp_eng_e est;
      logic [15:0] addr;
      logic [7:0] cnt;
      logic blank_ok;
      logic verify_fail;
      logic bad_cmd;
      logic blocked;
      logic overrun;
      logic [1:0] mode;
      logic busy;
      logic [7:0] status;
   } sfp_dev_s;

   sfp_dev_s st_r;
   sfp_dev_s st_nxt;
   logic [7:0] flash [FLASH_BYTES];
   logic [7:0] rd;
   logic mem_we;
   logic [7:0] mem_wd;
   logic fifo_rdy;
   logic fifo_vld;
   logic [7:0] fifo_d;
   logic eng_pop;
   logic vpp_hi;
   logic vpp_rise;
   logic ck_now;
   logic ck_old;
   logic din;
   logic ck_rise;
   logic ck_fall;
   logic last;

   assign vpp_hi = st_r.s2[SY_VPP];
   assign vpp_rise = st_r.s2[SY_VPP] & ~st_r.s3[SY_VPP];
   // Port one pins feed the same synchroniser and rx/tx shifters as the serial port pins
   assign ck_now = st_r.pseudo ? st_r.s2[SY_PCK] : st_r.s2[SY_HCK]; // RL3
   assign ck_old = st_r.pseudo ? st_r.s3[SY_PCK] : st_r.s3[SY_HCK];
   assign din = st_r.pseudo ? st_r.s2[SY_PDI] : st_r.s2[SY_HDI];
   assign ck_rise = ck_now & ~ck_old;
   assign ck_fall = ~ck_now & ck_old;
   assign rd = flash[st_r.addr[AW-1:0]];
   assign last = (st_r.addr == 16'(FLASH_BYTES - 1));

   sfp_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .i_clock(i_clock),
      .i_nrst(i_nrst),
      .i_valid(st_r.push),
      .i_data(st_r.pushd),
      .o_ready(fifo_rdy),
      .o_valid(fifo_vld),
      .o_data(fifo_d),
      .i_ready(eng_pop)
   );

   always_comb begin
      st_nxt = st_r;
      eng_pop = 1'b0;
      mem_we = 1'b0;
      mem_wd = fifo_d;
      st_nxt.s1 = {link.port_one_bit_two, link.port_one_bit_zero, link.sio_data_in_pin,
                   link.sio_clock_pin, link.vpp};
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      st_nxt.push = 1'b0;
      // Time since the programming pin last changed level
      if (st_r.s2[SY_VPP] != st_r.s3[SY_VPP]) begin
         st_nxt.tcnt = '0;
      end else if (st_r.tcnt != 12'hfff) begin
         st_nxt.tcnt = st_r.tcnt + 1'b1;
      end

      // ----------------------------------------------------------------
      // Mode entry and link selection
      // ----------------------------------------------------------------
      case (st_r.lst)
         L_OFF: begin
            if (vpp_rise) begin // RL13
               st_nxt.lst = L_INIT;
               st_nxt.pulses = '0;
               st_nxt.blank_ok = 1'b0;
               st_nxt.verify_fail = 1'b0;
               st_nxt.bad_cmd = 1'b0;
               st_nxt.blocked = 1'b0;
               st_nxt.overrun = 1'b0;
            end
         end
         L_INIT: begin
            if (vpp_rise && st_r.pulses != PULSES_MAX) begin
               st_nxt.pulses = st_r.pulses + 1'b1;
            end
            if (vpp_hi && st_r.tcnt >= SELECT_CYC) begin
               st_nxt.bitcnt = '0;
               st_nxt.tx = st_r.status;
               if (st_r.pulses == PULSES_HW) begin
                  st_nxt.lst = L_LINK; // RL1
                  st_nxt.doe_hw = 1'b1; // RL4
                  st_nxt.mode = MODE_HW;
               end else if (st_r.pulses == PULSES_PSEUDO) begin
                  st_nxt.lst = L_LINK; // RL2
                  st_nxt.pseudo = 1'b1;
                  st_nxt.doe_p1 = 1'b1; // RL4
                  st_nxt.mode = MODE_PSEUDO;
               end else begin
                  st_nxt.lst = L_BAD; // RL12
               end
            end
         end
         L_LINK: begin
            if (ck_rise) begin
               st_nxt.rx = {st_r.rx[6:0], din};
               st_nxt.bitcnt = st_r.bitcnt + 1'b1;
               if (st_r.bitcnt == 3'h7) begin
                  st_nxt.push = 1'b1; // RL6
                  st_nxt.pushd = {st_r.rx[6:0], din};
               end
            end else if (ck_fall) begin
               // Reload on the last fall, never while sck is high
               st_nxt.tx = (st_r.bitcnt == 3'h0) ? st_r.status : {st_r.tx[6:0], 1'b0};
            end
         end
         default: begin
         end
      endcase
      // A long low on the programming pin ends the session; pulses are shorter
      if (st_r.lst != L_OFF && !vpp_hi && st_r.tcnt >= EXIT_CYC) begin
         st_nxt.lst = L_OFF;
         st_nxt.pseudo = 1'b0;
         st_nxt.doe_hw = 1'b0;
         st_nxt.doe_p1 = 1'b0;
         st_nxt.mode = MODE_NONE;
         st_nxt.est = E_IDLE;
      end

      // ----------------------------------------------------------------
      // Command engine
      // ----------------------------------------------------------------
      case (st_r.est)
         E_IDLE: begin
            if (fifo_vld) begin
               eng_pop = 1'b1; // RL6
               case (fifo_d)
                  CMD_ERASE: begin
                     if (vpp_hi) begin
                        st_nxt.est = E_ERASE;
                        st_nxt.addr = '0;
                     end else begin
                        st_nxt.blocked = 1'b1; // RL13
                     end
                  end
                  CMD_BLANK: begin
                     st_nxt.est = E_BLANK;
                     st_nxt.addr = '0;
                     st_nxt.blank_ok = 1'b1;
                  end
                  CMD_WRITE: st_nxt.est = E_ADRH;
                  CMD_VERIFY: begin
                     st_nxt.est = E_VERIFY;
                     st_nxt.addr = '0;
                     st_nxt.verify_fail = 1'b0;
                  end
                  CMD_STATUS: begin
                     st_nxt.bad_cmd = 1'b0;
                     st_nxt.blocked = 1'b0;
                     st_nxt.overrun = 1'b0;
                  end
                  default: st_nxt.bad_cmd = 1'b1;
               endcase
            end
         end
         E_ERASE: begin
            mem_we = 1'b1; // RL7
            mem_wd = ERASED_BYTE;
            st_nxt.addr = st_r.addr + 1'b1;
            st_nxt.blank_ok = 1'b0;
            if (last) begin
               st_nxt.est = E_IDLE;
            end
         end
         E_BLANK: begin
            if (rd != ERASED_BYTE) begin
               st_nxt.blank_ok = 1'b0; // RL8
            end
            st_nxt.addr = st_r.addr + 1'b1;
            if (last) begin
               st_nxt.est = E_IDLE;
            end
         end
         E_ADRH: begin
            if (fifo_vld) begin
               eng_pop = 1'b1;
               st_nxt.addr[15:8] = fifo_d; // RL9
               st_nxt.est = E_ADRL;
            end
         end
         E_ADRL: begin
            if (fifo_vld) begin
               eng_pop = 1'b1;
               st_nxt.addr[7:0] = fifo_d; // RL9
               st_nxt.est = E_CNT;
            end
         end
         E_CNT: begin
            if (fifo_vld) begin
               eng_pop = 1'b1;
               st_nxt.cnt = fifo_d; // RL9
               st_nxt.est = (fifo_d == 8'h00) ? E_IDLE : E_DATA;
            end
         end
         E_DATA: begin
            if (fifo_vld) begin
               eng_pop = 1'b1;
               if (vpp_hi) begin
                  mem_we = 1'b1; // RL9
               end else begin
                  st_nxt.blocked = 1'b1; // RL13
               end
               st_nxt.addr = st_r.addr + 1'b1;
               st_nxt.cnt = st_r.cnt - 1'b1;
               if (st_r.cnt == 8'h01) begin
                  st_nxt.est = E_IDLE;
               end
            end
         end
         E_VERIFY: begin
            if (fifo_vld) begin
               eng_pop = 1'b1;
               if (fifo_d != rd) begin
                  st_nxt.verify_fail = 1'b1; // RL10
               end
               st_nxt.addr = st_r.addr + 1'b1;
               if (last) begin
                  st_nxt.est = E_IDLE;
               end
            end
         end
         default: st_nxt.est = E_IDLE;
      endcase
      // Set after the clears so a byte lost in the clearing cycle still shows
      if (st_r.push && !fifo_rdy) begin
         st_nxt.overrun = 1'b1;
      end

      st_nxt.busy = (st_nxt.est != E_IDLE);
      st_nxt.status = STATUS_RST;
      st_nxt.status[ST_BUSY] = st_nxt.busy;
      st_nxt.status[ST_BLANK_OK] = st_nxt.blank_ok;
      st_nxt.status[ST_VERIFY_FAIL] = st_nxt.verify_fail;
      st_nxt.status[ST_BAD_CMD] = st_nxt.bad_cmd;
      st_nxt.status[ST_BLOCKED] = st_nxt.blocked;
      st_nxt.status[ST_OVERRUN] = st_nxt.overrun;
      st_nxt.status[ST_MODE_LSB +: 2] = st_nxt.mode;
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         st_r <= '0;
         st_r.lst <= L_OFF;
         st_r.est <= E_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Array has no reset; software erases before relying on it
   always_ff @(posedge i_clock) begin
      if (mem_we) begin
         flash[st_r.addr[AW-1:0]] <= mem_wd;
      end
   end

   assign link.sio_data_out_pin = st_r.tx[7];
   assign link.sio_data_out_pin_oe = st_r.doe_hw;
   assign link.port_one_bit_one = st_r.tx[7];
   assign link.port_one_bit_one_oe = st_r.doe_p1;
   assign o_link_mode = st_r.mode;
   assign o_busy = st_r.busy;
   assign o_status = st_r.status;
endmodule : sfp_device

// File: design/sfp_programmer.sv
// Programmer end: pulses the programming pin to pick a link, then moves
// bytes as serial clock master; optionally supplies the target clock.
// Assumes the target samples on rising sck and shifts on falling sck.
`timescale 1ns/100ps
module sfp_programmer import sfp_pkg::*; (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_nrst,
   // Link pins
   sfp_link_if.prg link,
   // Session control
   input wire logic i_start,
   input wire logic i_pseudo,
   input wire logic i_stop,
   input wire logic i_clk_supply,
   output logic o_active,
   // Byte exchange
   input wire logic i_tx_valid,
   input wire logic [7:0] i_tx_byte,
   output logic o_tx_ready,
   output logic o_rx_valid,
   output logic [7:0] o_rx_byte
);
   typedef struct packed {
      sfp_prg_e st;
      logic pseudo;
      logic [4:0] remain;
      logic [11:0] tmr;
      logic vpp;
      logic sck;
      logic sdo;
      logic [3:0] pins;
      logic [7:0] tx;
      logic [7:0] rx;
      logic [2:0] bitn;
      logic rxv;
      logic rdy;
      logic active;
      logic xclk;
      logic xoe;
      logic [1:0] s1;
      logic [1:0] s2;
   } sfp_prg_s;

   sfp_prg_s st_r;
   sfp_prg_s st_nxt;
   logic tdone;
   logic din;

   assign tdone = (st_r.tmr == 12'h001);
   assign din = st_r.pseudo ? st_r.s2[1] : st_r.s2[0];

   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = {link.port_one_bit_one, link.sio_data_out_pin};
      st_nxt.s2 = st_r.s1;
      st_nxt.rxv = 1'b0;
      if (st_r.tmr != 12'h000) begin
         st_nxt.tmr = st_r.tmr - 1'b1;
      end
      // Divided clock only when the target has no resonator of its own
      st_nxt.xoe = i_clk_supply; // RL11
      st_nxt.xclk = i_clk_supply & ~st_r.xclk;

      case (st_r.st)
         P_IDLE: begin
            if (i_start) begin
               st_nxt.vpp = 1'b1;
               st_nxt.pseudo = i_pseudo;
               st_nxt.remain = i_pseudo ? PULSES_PSEUDO : PULSES_HW; // RL5
               st_nxt.tmr = PULSE_CYC;
               st_nxt.st = P_HI;
            end
         end
         P_HI: begin
            if (tdone) begin
               if (st_r.remain == 5'h00) begin
                  st_nxt.tmr = SETTLE_CYC;
                  st_nxt.st = P_SETTLE;
               end else begin
                  st_nxt.vpp = 1'b0;
                  st_nxt.tmr = PULSE_CYC;
                  st_nxt.st = P_LO;
               end
            end
         end
         P_LO: begin
            if (tdone) begin
               st_nxt.vpp = 1'b1;
               st_nxt.remain = st_r.remain - 1'b1;
               st_nxt.tmr = PULSE_CYC;
               st_nxt.st = P_HI;
            end
         end
         P_SETTLE: begin
            if (tdone) begin
               st_nxt.st = P_READY; // RL5
            end
         end
         P_READY: begin
            if (i_stop) begin
               st_nxt.vpp = 1'b0;
               st_nxt.tmr = END_CYC;
               st_nxt.st = P_END;
            end else if (i_tx_valid) begin
               st_nxt.tx = i_tx_byte; // RL6
               st_nxt.sdo = i_tx_byte[7];
               st_nxt.bitn = '0;
               st_nxt.tmr = SCK_HALF_CYC;
               st_nxt.st = P_CKLO;
            end
         end
         P_CKLO: begin
            if (tdone) begin
               st_nxt.sck = 1'b1;
               st_nxt.rx = {st_r.rx[6:0], din};
               st_nxt.tmr = SCK_HALF_CYC;
               st_nxt.st = P_CKHI;
            end
         end
         P_CKHI: begin
            if (tdone) begin
               st_nxt.sck = 1'b0;
               if (st_r.bitn == 3'h7) begin
                  st_nxt.rxv = 1'b1;
                  st_nxt.st = P_READY;
               end else begin
                  st_nxt.bitn = st_r.bitn + 1'b1;
                  st_nxt.tx = {st_r.tx[6:0], 1'b0};
                  st_nxt.sdo = st_r.tx[6];
                  st_nxt.tmr = SCK_HALF_CYC;
                  st_nxt.st = P_CKLO;
               end
            end
         end
         P_END: begin
            if (tdone) begin
               st_nxt.st = P_IDLE;
            end
         end
         default: st_nxt.st = P_IDLE;
      endcase

      // Only the chosen link's pins toggle; the other pair rests low
      st_nxt.pins = st_nxt.pseudo ? {st_nxt.sdo, st_nxt.sck, 2'h0} : {2'h0, st_nxt.sdo, st_nxt.sck};
      st_nxt.rdy = (st_nxt.st == P_READY) & ~i_stop;
      st_nxt.active = st_nxt.st inside {P_READY, P_CKLO, P_CKHI};
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         st_r <= '0;
         st_r.st <= P_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign link.vpp = st_r.vpp;
   assign link.crystal_input = st_r.xclk;
   assign link.crystal_input_oe = st_r.xoe;
   assign link.sio_clock_pin = st_r.pins[0];
   assign link.sio_data_in_pin = st_r.pins[1];
   assign link.port_one_bit_zero = st_r.pins[2];
   assign link.port_one_bit_two = st_r.pins[3];
   assign o_active = st_r.active;
   assign o_tx_ready = st_r.rdy;
   assign o_rx_valid = st_r.rxv;
   assign o_rx_byte = st_r.rx;
endmodule : sfp_programmer

// File: test/sfp_link_asserts.sv
// Checker on the link pins between programmer and device.
// Assumes both ends share i_clock; takes the pins as plain inputs.
`timescale 1ns/100ps
module sfp_link_asserts (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_nrst,
   // Link pins
   input wire logic vpp,
   input wire logic sio_clock_pin,
   input wire logic sio_data_in_pin,
   input wire logic sio_data_out_pin,
   input wire logic sio_data_out_pin_oe,
   input wire logic port_one_bit_zero,
   input wire logic port_one_bit_one,
   input wire logic port_one_bit_one_oe
);
   logic [8:0] hi_r;
   logic [8:0] lo_r;
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_nrst);
   // Saturating run lengths of the programming pin level
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         hi_r <= 9'h000;
         lo_r <= 9'h000;
      end else begin
         hi_r <= !vpp ? 9'h000 : hi_r + 9'(hi_r != 9'h1ff);
         lo_r <= vpp ? 9'h000 : lo_r + 9'(lo_r != 9'h1ff);
      end
   end
   sequence s_sck_hi; sio_clock_pin [*8]; endsequence
   sequence s_pck_hi; port_one_bit_zero [*8]; endsequence
   property p_hw_sel; $rose(sio_data_out_pin_oe) |-> hi_r >= 9'd188; endproperty
   a_hw_sel: assert property (p_hw_sel) else $error("hw select early");
   property p_ps_sel; $rose(port_one_bit_one_oe) |-> hi_r >= 9'd188; endproperty
   a_ps_sel: assert property (p_ps_sel) else $error("port select early");
   property p_one; port_one_bit_one_oe |-> !sio_data_out_pin_oe; endproperty
   a_one: assert property (p_one) else $error("two links");
   property p_exit; lo_r >= 9'd260 |-> !sio_data_out_pin_oe && !port_one_bit_one_oe; endproperty
   a_exit: assert property (p_exit) else $error("link after exit");
   property p_hw_idle; port_one_bit_one_oe |-> !sio_clock_pin && !sio_data_in_pin; endproperty
   a_hw_idle: assert property (p_hw_idle) else $error("hw pins moved");
   property p_sck; $rose(sio_clock_pin) |-> s_sck_hi; endproperty
   a_sck: assert property (p_sck) else $error("hw sck short");
   property p_pck; $rose(port_one_bit_zero) |-> s_pck_hi; endproperty
   a_pck: assert property (p_pck) else $error("port sck short");
   property p_dout; sio_clock_pin && sio_data_out_pin_oe |-> $stable(sio_data_out_pin); endproperty
   a_dout: assert property (p_dout) else $error("hw reply moved");
   property p_pout; port_one_bit_zero && port_one_bit_one_oe |-> $stable(port_one_bit_one);
   endproperty
   a_pout: assert property (p_pout) else $error("port reply moved");
endmodule : sfp_link_asserts

// File: test/serial_flash_programming_mode_bench.sv
// Bench: programmer and device joined by the link; user sides driven here.
// Assumes a 125 MHz clock shared by both ends.
`timescale 1ns/100ps
module serial_flash_programming_mode_bench import sfp_pkg::*;;
   logic i_clock = 1'b0, i_nrst = 1'b0, start = 1'b0, pseudo = 1'b0;
   logic stop = 1'b0, clk_sup = 1'b0, tx_valid = 1'b0, active, tx_ready, rx_valid, busy;
   logic [7:0] tx_byte = 8'h00, rx_byte, status, d;
   logic [1:0] mode;
   logic [15:0] exp_q[$];
   logic [15:0] e;
   logic [31:0] seed = 32'h7e3d70d5;
   int miscompares = 0, cmp_count = 0;
   sfp_link_if link ();
   always #4 i_clock = ~i_clock;
   sfp_programmer sfp_programmer_inst (.i_clock(i_clock), .i_nrst(i_nrst), .link(link),
      .i_start(start), .i_pseudo(pseudo), .i_stop(stop), .i_clk_supply(clk_sup),
      .o_active(active), .i_tx_valid(tx_valid), .i_tx_byte(tx_byte),
      .o_tx_ready(tx_ready), .o_rx_valid(rx_valid), .o_rx_byte(rx_byte));
   // Small array keeps erase, blank check and verify short
   sfp_device #(.FLASH_BYTES(256), .FIFO_DEPTH(8)) sfp_device_inst (.i_clock(i_clock),
      .i_nrst(i_nrst), .link(link), .o_link_mode(mode), .o_busy(busy), .o_status(status));
   sfp_link_asserts sfp_link_asserts_inst (.i_clock(i_clock), .i_nrst(i_nrst),
      .vpp(link.vpp), .sio_clock_pin(link.sio_clock_pin),
      .sio_data_in_pin(link.sio_data_in_pin), .sio_data_out_pin(link.sio_data_out_pin),
      .sio_data_out_pin_oe(link.sio_data_out_pin_oe),
      .port_one_bit_zero(link.port_one_bit_zero), .port_one_bit_one(link.port_one_bit_one),
      .port_one_bit_one_oe(link.port_one_bit_one_oe));
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   task automatic check(input logic [7:0] got, input logic [7:0] want);
      cmp_count++;
      if (got !== want) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, got, want);
      end
   endtask : check
   task automatic hang();
      miscompares++;
      $display("unexpected at %0t: wait ran out", $time);
      give_verdict();
   endtask : hang
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xorshift
   // x is {mask, value} of the reply
   task automatic xfer(input logic [7:0] b, input logic [15:0] x);
      @(posedge i_clock);
      #1;
      exp_q.push_back(x);
      tx_valid = 1'b1;
      tx_byte = b;
      for (int n = 0; tx_ready !== 1'b1; n++) begin
         @(posedge i_clock);
         #1;
         if (n > 600) hang();
      end
      @(posedge i_clock);
      #1;
      tx_valid = 1'b0;
   endtask : xfer
   task automatic session(input logic p, input logic [1:0] m);
      start = 1'b1;
      pseudo = p;
      @(posedge i_clock);
      #1;
      start = 1'b0;
      for (int n = 0; tx_ready !== 1'b1; n++) begin
         @(posedge i_clock);
         #1;
         if (n > 6000) hang();
      end
      check({6'h00, mode}, {6'h00, m});
   endtask : session
   always @(negedge i_clock) begin
      if (rx_valid === 1'b1) begin
         e = exp_q.pop_front();
         check(rx_byte & e[15:8], e[7:0]);
      end
   end
   initial begin
      repeat (20) @(posedge i_clock);
      #1;
      i_nrst = 1'b1;
      session(1'b0, MODE_HW);
      xfer(CMD_ERASE, 16'hff00);
      repeat (2) xfer(CMD_STATUS, 16'h0000);
      xfer(CMD_BLANK, 16'h0000);
      repeat (3) xfer(CMD_STATUS, 16'h0000);
      xfer(CMD_STATUS, 16'h0302);
      seed = xorshift(seed);
      d = seed[7:0];
      xfer(CMD_WRITE, 16'h0000);
      xfer(8'h00, 16'h0000);
      xfer(8'h10, 16'h0000);
      xfer(8'h01, 16'h0000);
      xfer(d, 16'h0000);
      stop = 1'b1;
      repeat (700) @(posedge i_clock);
      #1;
      stop = 1'b0;
      check({7'h00, active}, 8'h00);
      check({6'h00, mode}, {6'h00, MODE_NONE});
      clk_sup = 1'b1;
      session(1'b1, MODE_PSEUDO);
      check({7'h00, link.crystal_input_oe}, 8'h01);
      xfer(CMD_VERIFY, 16'hc000);
      for (int i = 0; i < 256; i++) xfer(i == 16 ? d : ERASED_BYTE, 16'h0000);
      repeat (2) xfer(CMD_STATUS, 16'h0000);
      xfer(CMD_STATUS, 16'h0500);
      for (int n = 0; exp_q.size() > 0; n++) begin
         @(posedge i_clock);
         if (n > 2000) hang();
      end
      check({7'h00, busy}, 8'h00);
      give_verdict();
   end
endmodule : serial_flash_programming_mode_bench
